// [core/hsdc_top.sv]
// Purpose: Control and fault logic for two high-side switches behind the serial port
// Assumes: All inputs synchronous to clk_sys; mode supplied by the mode controller
// Notes:   Shutdowns latch until a control write made after the cause has gone
//
// Summary of operation
// - Each switch turns on or off with its own enable bit in the control register.
// - With enable and pulse-select both set, a switch follows the direct pulse input.
// - Open-load flag of an enabled channel shows low load current, bits 1 and 3.
// - Current-limit flag shows a driver in current limitation, bits 0 and 2.
// - Overtemperature on either driver turns both switches off together.
// - A thermal shutdown sets every open-load and current-limit flag at once.
// - The thermal shutdown event is latched until software services it.
// - The shutdown is reported with source code 0010 in the source register.
// - With the high-side mask bit set, the event pulls the interrupt output low.
// - A masked source keeps the interrupt output high and its source flag clear.
// - Interrupts arise only in Normal, Normal Request or Stop mode.
// - After a thermal shutdown only a control write with the heat gone re-enables.
// - Enabled overvoltage shutdown in Normal mode turns both off until a write after it ends.
`timescale 1ns/1ps
module hsdc_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Serial register port
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Direct pulse control
   input wire logic direct_pulse_input,
   // Driver sense, index 0 is switch one
   input wire hsdc_pkg::hsdc_sense_s [1:0] chan_sense,
   // Supply and mode
   input wire logic supply_overvoltage,
   input wire logic overvoltage_shutdown_enable,
   input wire hsdc_pkg::hsdc_mode_e op_mode,
   // Outputs
   output logic [1:0] switch_drive,
   output logic irq_n
);

   // Control and interrupt state
   logic [3:0] high_side_control_reg_ff, nxt_high_side_control_reg;
   logic high_side_irq_mask_ff, nxt_high_side_irq_mask;
   logic thermal_off_ff, nxt_thermal_off;
   logic volt_off_ff, nxt_volt_off;
   logic src_hs_ff, nxt_src_hs;
   logic irq_n_ff, nxt_irq_n;

   // Serial slave connections
   logic [3:0] addr_nib;
   logic [3:0] rd_nib;
   logic [3:0] sys_nib;
   logic [7:0] frame_byte;
   logic frame_valid;

   // Channel connections
   hsdc_pkg::hsdc_ctrl_s [1:0] chan_ctrl;
   hsdc_pkg::hsdc_flags_s [1:0] chan_flags;
   logic [1:0] chan_drive;
   logic [3:0] high_side_status_reg;
   logic [3:0] interrupt_source_reg;
   logic over_temp_any;
   logic shutdown_all;
   logic hs_write;
   logic int_write;
   logic hs_event;
   logic mode_ok;

   hsdc_spi u_spi (
      .clk_sys(clk_sys),
      .srst(srst),
      .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi),
      .miso_ff(spi_miso),
      .miso_oe_ff(spi_miso_oe),
      .sys_nib(sys_nib),
      .rd_nib(rd_nib),
      .addr_nib(addr_nib),
      .frame_ff(frame_valid),
      .frame_byte(frame_byte)
   );

   assign chan_ctrl[0].enable = high_side_control_reg_ff[hsdc_pkg::CTRL_EN1_BIT];
   assign chan_ctrl[0].pulse_select = high_side_control_reg_ff[hsdc_pkg::CTRL_PSEL1_BIT];
   assign chan_ctrl[1].enable = high_side_control_reg_ff[hsdc_pkg::CTRL_EN2_BIT];
   assign chan_ctrl[1].pulse_select = high_side_control_reg_ff[hsdc_pkg::CTRL_PSEL2_BIT];

   // Immediate cut on a live overtemperature, then the latches hold it
   assign over_temp_any = chan_sense[0].over_temp || chan_sense[1].over_temp;
   assign shutdown_all = over_temp_any || thermal_off_ff || volt_off_ff;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
         hsdc_channel u_chan (
            .clk_sys(clk_sys),
            .srst(srst),
            .ctrl(chan_ctrl[gi]),
            .direct_pulse_input(direct_pulse_input),
            .shutdown(shutdown_all),
            .thermal_latched(thermal_off_ff),
            .sense(chan_sense[gi]),
            .drive_ff(chan_drive[gi]),
            .flags_ff(chan_flags[gi])
         );
      end
   endgenerate

   assign switch_drive = chan_drive;
   assign irq_n = irq_n_ff;

   // Status map of both channels
   assign high_side_status_reg[hsdc_pkg::STAT_CL1_BIT] = chan_flags[0].current_limit;
   assign high_side_status_reg[hsdc_pkg::STAT_OP1_BIT] = chan_flags[0].open_load;
   assign high_side_status_reg[hsdc_pkg::STAT_CL2_BIT] = chan_flags[1].current_limit;
   assign high_side_status_reg[hsdc_pkg::STAT_OP2_BIT] = chan_flags[1].open_load;

   assign interrupt_source_reg = src_hs_ff ? hsdc_pkg::SRC_CODE_HIGH_SIDE :
                                 hsdc_pkg::SRC_CODE_NONE;

   always_comb begin
      sys_nib = 4'h0;
      sys_nib[hsdc_pkg::SYS_HSS_BIT] = |high_side_status_reg;
   end

   // Read data for the addressed register
   always_comb begin
      case (addr_nib)
         hsdc_pkg::ADDR_HIGH_SIDE: rd_nib = high_side_status_reg;
         hsdc_pkg::ADDR_INTERRUPT: rd_nib = interrupt_source_reg;
         default: rd_nib = 4'h0;
      endcase
   end

   assign hs_write = frame_valid && (frame_byte[7:4] == hsdc_pkg::ADDR_HIGH_SIDE);
   assign int_write = frame_valid && (frame_byte[7:4] == hsdc_pkg::ADDR_INTERRUPT);
   assign hs_event = over_temp_any && !thermal_off_ff;
   assign mode_ok = hsdc_pkg::irq_mode_ok(op_mode);

   // Control registers and shutdown latches
   always_comb begin
      nxt_high_side_control_reg = high_side_control_reg_ff;
      nxt_high_side_irq_mask = high_side_irq_mask_ff;
      nxt_thermal_off = thermal_off_ff;
      nxt_volt_off = volt_off_ff;
      if (hs_write) begin
         nxt_high_side_control_reg = frame_byte[3:0];
         if (!over_temp_any) begin
            nxt_thermal_off = 1'b0;
         end
         if (!supply_overvoltage) begin
            nxt_volt_off = 1'b0;
         end
      end
      if (int_write) begin
         nxt_high_side_irq_mask = frame_byte[hsdc_pkg::MASK_HS_BIT];
      end
      // Set wins over a write in the same cycle
      if (over_temp_any) begin
         nxt_thermal_off = 1'b1;
      end
      if (supply_overvoltage && overvoltage_shutdown_enable &&
          op_mode == hsdc_pkg::MODE_NORMAL) begin
         nxt_volt_off = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         high_side_control_reg_ff <= hsdc_pkg::CTRL_RESET;
         high_side_irq_mask_ff <= hsdc_pkg::MASK_HS_RESET;
         thermal_off_ff <= 1'b0;
         volt_off_ff <= 1'b0;
      end else begin
         high_side_control_reg_ff <= nxt_high_side_control_reg;
         high_side_irq_mask_ff <= nxt_high_side_irq_mask;
         thermal_off_ff <= nxt_thermal_off;
         volt_off_ff <= nxt_volt_off;
      end
   end

   // Interrupt source latch and request output
   always_comb begin
      nxt_src_hs = src_hs_ff;
      // A complete eight-bit frame to the interrupt register services the event
      if (int_write) begin
         nxt_src_hs = 1'b0;
      end
      if (!high_side_irq_mask_ff) begin
         nxt_src_hs = 1'b0;
      end
      if (hs_event && high_side_irq_mask_ff && mode_ok) begin
         nxt_src_hs = 1'b1;
      end
      nxt_irq_n = !(src_hs_ff && high_side_irq_mask_ff && mode_ok);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         src_hs_ff <= 1'b0;
         irq_n_ff <= 1'b1;
      end else begin
         src_hs_ff <= nxt_src_hs;
         irq_n_ff <= nxt_irq_n;
      end
   end

endmodule // hsdc_top

// [core/hsdc_pkg.sv]
// Purpose: Shared constants and types for the high-side driver control block
// Assumes: Register access over the device's 8-bit serial frame (4 address, 4 data bits)
// Notes:   Register addresses and bit positions are named once here
package hsdc_pkg;

   // Serial frame layout
   localparam logic [3:0] SPI_FRAME_BITS = 4'h8;
   localparam logic [3:0] SPI_ADDR_BITS = 4'h4;
   localparam logic [3:0] SPI_CNT_MAX = 4'hF;

   // Register addresses: one write register and one read register share each
   localparam logic [3:0] ADDR_HIGH_SIDE = 4'h9;
   localparam logic [3:0] ADDR_INTERRUPT = 4'h3;

   // High-side control register fields
   localparam int CTRL_EN1_BIT = 0;
   localparam int CTRL_EN2_BIT = 1;
   localparam int CTRL_PSEL2_BIT = 2;
   localparam int CTRL_PSEL1_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // High-side status register fields
   localparam int STAT_CL1_BIT = 0;
   localparam int STAT_OP1_BIT = 1;
   localparam int STAT_CL2_BIT = 2;
   localparam int STAT_OP2_BIT = 3;

   // Interrupt mask register field and reset value
   localparam int MASK_HS_BIT = 2;
   localparam logic MASK_HS_RESET = 1'b0;

   // Interrupt source codes
   localparam logic [3:0] SRC_CODE_NONE = 4'h0;
   localparam logic [3:0] SRC_CODE_HIGH_SIDE = 4'h2;

   // System status nibble, high-side summary bit
   localparam int SYS_HSS_BIT = 1;

   // Operating modes of the device
   typedef enum logic [2:0] {
      MODE_RESET,
      MODE_NORMAL_REQUEST,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP
   } hsdc_mode_e;

   // Serial slave states
   typedef enum logic [0:0] {
      SPI_IDLE,
      SPI_ACTIVE
   } hsdc_spi_state_e;

   // Analog sense inputs of one driver
   typedef struct packed {
      logic open_load;
      logic current_limit;
      logic over_temp;
   } hsdc_sense_s;

   // Control bits of one driver
   typedef struct packed {
      logic enable;
      logic pulse_select;
   } hsdc_ctrl_s;

   // Reported flags of one driver
   typedef struct packed {
      logic open_load;
      logic current_limit;
   } hsdc_flags_s;

   // Modes in which interrupts may be raised
   function automatic logic irq_mode_ok(input hsdc_mode_e mode);
      irq_mode_ok = (mode == MODE_NORMAL) || (mode == MODE_NORMAL_REQUEST) ||
                    (mode == MODE_STOP);
   endfunction

endpackage

// [core/hsdc_channel.sv]
// Purpose: One high-side switch: drive decision and live status flags
// Assumes: Sense inputs synchronous to clk_sys
// Notes:   Shutdown forces the switch off; thermal latch forces both flags set
`timescale 1ns/1ps
module hsdc_channel (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Control
   input wire hsdc_pkg::hsdc_ctrl_s ctrl,
   input wire logic direct_pulse_input,
   input wire logic shutdown,
   input wire logic thermal_latched,
   // Sense
   input wire hsdc_pkg::hsdc_sense_s sense,
   // Results
   output logic drive_ff,
   output hsdc_pkg::hsdc_flags_s flags_ff
);

   logic nxt_drive;
   hsdc_pkg::hsdc_flags_s nxt_flags;

   always_comb begin
      if (shutdown) begin
         nxt_drive = 1'b0;
      end else if (ctrl.enable && ctrl.pulse_select) begin
         nxt_drive = direct_pulse_input;
      end else begin
         nxt_drive = ctrl.enable;
      end
      if (thermal_latched) begin
         nxt_flags.open_load = 1'b1;
         nxt_flags.current_limit = 1'b1;
      end else begin
         nxt_flags.open_load = ctrl.enable && sense.open_load;
         nxt_flags.current_limit = drive_ff && sense.current_limit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         drive_ff <= 1'b0;
         flags_ff <= '0;
      end else begin
         drive_ff <= nxt_drive;
         flags_ff <= nxt_flags;
      end
   end

endmodule // hsdc_channel

// [core/hsdc_spi.sv]
// Purpose: Serial register slave, one 8-bit frame per chip-select low phase
// Assumes: Pins synchronous to clk_sys; clock idles low; sample on falling edge
// Notes:   Frame is valid only with exactly eight falling edges
`timescale 1ns/1ps
module hsdc_spi (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Serial pins
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic miso_ff,
   output logic miso_oe_ff,
   // Register side
   input wire logic [3:0] sys_nib,
   input wire logic [3:0] rd_nib,
   output logic [3:0] addr_nib,
   output logic frame_ff,
   output logic [7:0] frame_byte
);

   hsdc_pkg::hsdc_spi_state_e state_ff, nxt_state;
   logic sclk_q_ff, nxt_sclk_q;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] rx_ff, nxt_rx;
   logic [7:0] tx_ff, nxt_tx;
   logic [2:0] idx_ff, nxt_idx;
   logic nxt_miso, nxt_miso_oe, nxt_frame;
   logic sclk_fall, sclk_rise;

   assign sclk_fall = sclk_q_ff && !spi_sclk;
   assign sclk_rise = !sclk_q_ff && spi_sclk;
   assign addr_nib = rx_ff[3:0];
   assign frame_byte = rx_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_sclk_q = spi_sclk;
      nxt_cnt = cnt_ff;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_idx = idx_ff;
      nxt_miso_oe = miso_oe_ff;
      nxt_frame = 1'b0;
      case (state_ff)
         hsdc_pkg::SPI_IDLE: begin
            nxt_miso_oe = 1'b0;
            if (!spi_cs_n) begin
               nxt_state = hsdc_pkg::SPI_ACTIVE;
               nxt_cnt = 4'h0;
               nxt_idx = 3'h0;
               nxt_tx = {sys_nib, 4'h0};
               nxt_miso_oe = 1'b1;
            end
         end
         hsdc_pkg::SPI_ACTIVE: begin
            if (spi_cs_n) begin
               nxt_state = hsdc_pkg::SPI_IDLE;
               nxt_miso_oe = 1'b0;
               nxt_frame = (cnt_ff == hsdc_pkg::SPI_FRAME_BITS);
            end else begin
               if (sclk_fall) begin
                  nxt_rx = {rx_ff[6:0], spi_mosi};
                  if (cnt_ff != hsdc_pkg::SPI_CNT_MAX) begin
                     nxt_cnt = cnt_ff + 4'h1;
                  end
               end
               // Reply data follows once the address nibble is in
               if (cnt_ff == hsdc_pkg::SPI_ADDR_BITS) begin
                  nxt_tx[3:0] = rd_nib;
               end
               if (sclk_rise && cnt_ff != 4'h0 && idx_ff != 3'h7) begin
                  nxt_idx = idx_ff + 3'h1;
               end
            end
         end
         default: begin
            nxt_state = hsdc_pkg::SPI_IDLE;
            nxt_miso_oe = 1'b0;
         end
      endcase
      nxt_miso = nxt_tx[3'h7 - nxt_idx];
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_ff <= hsdc_pkg::SPI_IDLE;
         sclk_q_ff <= 1'b0;
         cnt_ff <= 4'h0;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         idx_ff <= 3'h0;
         miso_ff <= 1'b0;
         miso_oe_ff <= 1'b0;
         frame_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sclk_q_ff <= nxt_sclk_q;
         cnt_ff <= nxt_cnt;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         idx_ff <= nxt_idx;
         miso_ff <= nxt_miso;
         miso_oe_ff <= nxt_miso_oe;
         frame_ff <= nxt_frame;
      end
   end

endmodule // hsdc_spi

// [tb/hsdc_top_properties.sv]
// Purpose: Port-level assertions for the high-side driver control block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to hsdc_top below
`timescale 1ns/1ps
module hsdc_top_properties (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Serial port
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   // Control and sense
   input wire logic direct_pulse_input,
   input wire hsdc_pkg::hsdc_sense_s [1:0] chan_sense,
   input wire logic supply_overvoltage,
   input wire logic overvoltage_shutdown_enable,
   input wire hsdc_pkg::hsdc_mode_e op_mode,
   // Outputs
   input wire logic [1:0] switch_drive,
   input wire logic irq_n
);
   logic ot;
   logic mode_ok;
   assign ot = chan_sense[0].over_temp | chan_sense[1].over_temp;
   assign mode_ok = (op_mode == hsdc_pkg::MODE_NORMAL) ||
                    (op_mode == hsdc_pkg::MODE_NORMAL_REQUEST) ||
                    (op_mode == hsdc_pkg::MODE_STOP);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   // No frame can start inside these windows; a write from one ending just before lands by their second cycle
   sequence cs_idle_s;
      spi_cs_n [*4];
   endsequence
   sequence quiet_s;
      (spi_cs_n && !ot && !supply_overvoltage) [*5];
   endsequence

   ot_shutoff_a: assert property (ot |=> switch_drive == 2'b00)
      else $error("Switch on after overtemperature");
   heat_latch_a: assert property (
      cs_idle_s ##0 ot ##1 cs_idle_s |=> switch_drive == 2'b00)
      else $error("Thermal shutdown released without a write");
   idle_stable_a: assert property (
      quiet_s ##0 $stable(direct_pulse_input) |=> $stable(switch_drive))
      else $error("Switch changed with no cause");
   ov_shutoff_a: assert property (
      (supply_overvoltage && overvoltage_shutdown_enable &&
      op_mode == hsdc_pkg::MODE_NORMAL) [*2] |=> switch_drive == 2'b00)
      else $error("Switch on during overvoltage shutdown");
   irq_mode_a: assert property (!mode_ok |=> irq_n)
      else $error("Interrupt raised in a quiet mode");
   irq_cause_a: assert property (
      $fell(irq_n) && $past(op_mode) == $past(op_mode, 2) |-> $past(ot, 2))
      else $error("Interrupt without overtemperature event");
   oe_follow_a: assert property (1'b1 |=> spi_miso_oe == !$past(spi_cs_n))
      else $error("Output enable does not follow frame select");
   miso_first_a: assert property ($fell(spi_cs_n) |=> !spi_miso)
      else $error("First reply bit not zero");
endmodule // hsdc_top_properties

bind hsdc_top hsdc_top_properties u_props (
   .clk_sys(clk_sys), .srst(srst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
   .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
   .direct_pulse_input(direct_pulse_input), .chan_sense(chan_sense),
   .supply_overvoltage(supply_overvoltage),
   .overvoltage_shutdown_enable(overvoltage_shutdown_enable), .op_mode(op_mode),
   .switch_drive(switch_drive), .irq_n(irq_n));

// [tb/hsdc_load_model.sv]
// Purpose: Loads on the two high-side outputs, returning sense levels
// Assumes: Load faults and die heat are set by the bench
// Notes:   Behavioural, no delay
`timescale 1ns/1ps
module hsdc_load_model (
   // Switch drive
   input wire logic [1:0] switch_drive,
   // Load conditions
   input wire logic [1:0] load_open,
   input wire logic [1:0] load_short,
   input wire logic [1:0] die_hot,
   // Sense back
   output hsdc_pkg::hsdc_sense_s [1:0] chan_sense
);
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // Off switch or missing load carries no current
         chan_sense[i].open_load = !switch_drive[i] || load_open[i];
         chan_sense[i].current_limit = switch_drive[i] && load_short[i];
         chan_sense[i].over_temp = die_hot[i];
      end
   end
endmodule // hsdc_load_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the high-side driver control block
// Assumes: Frames timed as the serial port contract allows
// Notes:   Random control and load values from a fixed seed
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic spi_cs_n = 1'b1;
   logic spi_sclk = 1'b0;
   logic spi_mosi = 1'b0;
   logic direct_pulse_input = 1'b0;
   logic supply_overvoltage = 1'b0;
   logic overvoltage_shutdown_enable = 1'b0;
   hsdc_pkg::hsdc_mode_e op_mode = hsdc_pkg::MODE_NORMAL;
   logic [1:0] load_open = 2'b00;
   logic [1:0] load_short = 2'b00;
   logic [1:0] die_hot = 2'b00;
   hsdc_pkg::hsdc_sense_s [1:0] chan_sense;
   logic spi_miso;
   logic spi_miso_oe;
   logic [1:0] switch_drive;
   logic irq_n;
   logic [7:0] r;
   logic [3:0] c;
   logic [3:0] s;
   logic ok;
   int n_errors = 0;
   int comparisons = 0;
   integer seed = 19;

   hsdc_top DUT (.clk_sys(clk_sys), .srst(srst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .direct_pulse_input(direct_pulse_input), .chan_sense(chan_sense),
      .supply_overvoltage(supply_overvoltage),
      .overvoltage_shutdown_enable(overvoltage_shutdown_enable), .op_mode(op_mode),
      .switch_drive(switch_drive), .irq_n(irq_n));
   hsdc_load_model loads (.switch_drive(switch_drive), .load_open(load_open),
      .load_short(load_short), .die_hot(die_hot), .chan_sense(chan_sense));

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   function automatic logic [1:0] exp_drive(input logic [3:0] k, input logic p);
      exp_drive[0] = k[hsdc_pkg::CTRL_EN1_BIT] & (k[hsdc_pkg::CTRL_PSEL1_BIT] ? p : 1'b1);
      exp_drive[1] = k[hsdc_pkg::CTRL_EN2_BIT] & (k[hsdc_pkg::CTRL_PSEL2_BIT] ? p : 1'b1);
   endfunction

   function automatic logic [3:0] exp_stat(input logic [3:0] k, input logic [1:0] dr);
      exp_stat = 4'h0;
      exp_stat[hsdc_pkg::STAT_OP1_BIT] = k[hsdc_pkg::CTRL_EN1_BIT] & (!dr[0] | load_open[0]);
      exp_stat[hsdc_pkg::STAT_OP2_BIT] = k[hsdc_pkg::CTRL_EN2_BIT] & (!dr[1] | load_open[1]);
      exp_stat[hsdc_pkg::STAT_CL1_BIT] = dr[0] & load_short[0];
      exp_stat[hsdc_pkg::STAT_CL2_BIT] = dr[1] & load_short[1];
   endfunction

   task automatic end_sim;
      if (n_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   // Ends four rising edges after the frame, once the switch has updated
   task automatic spi_xfer(input logic [3:0] a, input logic [3:0] d, input int nf,
                           output logic [7:0] rep);
      logic [7:0] b;
      b = {a, d};
      rep = 8'h00;
      @(posedge clk_sys) spi_cs_n <= 1'b0;
      for (int i = 0; i < nf; i++) begin
         @(posedge clk_sys) begin
            spi_sclk <= 1'b1;
            spi_mosi <= b[7 - i];
         end
         @(posedge clk_sys);
         @(negedge clk_sys) rep[7 - i] = spi_miso;
         @(posedge clk_sys) spi_sclk <= 1'b0;
         @(posedge clk_sys);
      end
      @(posedge clk_sys) spi_cs_n <= 1'b1;
      settle(4);
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      settle(0);
      check({6'h00, switch_drive}, 8'h00);
      check({7'h00, irq_n}, 8'h01);
      for (int k = 0; k < 16; k++) begin
         c = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : 4'($random(seed));
         @(posedge clk_sys) begin
            direct_pulse_input <= 1'($random(seed));
            load_open <= 2'($random(seed));
            load_short <= 2'($random(seed));
         end
         spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, c, 8, r);
         check({6'h00, switch_drive}, {6'h00, exp_drive(c, direct_pulse_input)});
         @(posedge clk_sys) direct_pulse_input <= !direct_pulse_input;
         settle(1);
         check({6'h00, switch_drive}, {6'h00, exp_drive(c, direct_pulse_input)});
         spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, c, 8, r);
         s = exp_stat(c, exp_drive(c, direct_pulse_input));
         check(r, {2'b00, |s, 1'b0, s});
      end
      @(posedge clk_sys) begin
         load_open <= 2'b00;
         load_short <= 2'b00;
      end
      spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, 4'h3, 8, r);
      spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, 4'h0, 7, r);
      check({6'h00, switch_drive}, 8'h03);
      spi_xfer(4'h5, 4'h0, 8, r);
      check({4'h0, r[3:0]}, 8'h00);
      spi_xfer(hsdc_pkg::ADDR_INTERRUPT, 4'h4, 8, r);
      @(posedge clk_sys) die_hot <= 2'b10;
      settle(3);
      check({6'h00, switch_drive}, 8'h00);
      check({7'h00, irq_n}, 8'h00);
      spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, 4'h3, 8, r);
      @(posedge clk_sys) die_hot <= 2'b00;
      settle(3);
      check({6'h00, switch_drive}, 8'h00);
      check({7'h00, irq_n}, 8'h00);
      spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, 4'h3, 8, r);
      check(r, 8'h2F);
      check({6'h00, switch_drive}, 8'h03);
      spi_xfer(hsdc_pkg::ADDR_INTERRUPT, 4'h4, 8, r);
      check({4'h0, r[3:0]}, {4'h0, hsdc_pkg::SRC_CODE_HIGH_SIDE});
      check({7'h00, irq_n}, 8'h01);
      for (int mk = 0; mk < 2; mk++) begin
         for (int m = 0; m < 5; m++) begin
            ok = (mk == 1) && (m >= 1) && (m <= 3);
            spi_xfer(hsdc_pkg::ADDR_INTERRUPT, (mk == 1) ? 4'h4 : 4'h0, 8, r);
            @(posedge clk_sys) begin
               op_mode <= hsdc_pkg::hsdc_mode_e'(m);
               die_hot <= 2'b01;
            end
            settle(3);
            check({7'h00, irq_n}, {7'h00, !ok});
            @(posedge clk_sys) die_hot <= 2'b00;
            spi_xfer(hsdc_pkg::ADDR_INTERRUPT, (mk == 1) ? 4'h4 : 4'h0, 8, r);
            check({4'h0, r[3:0]}, ok ? {4'h0, hsdc_pkg::SRC_CODE_HIGH_SIDE} : 8'h00);
            spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, 4'h3, 8, r);
            check({6'h00, switch_drive}, 8'h03);
         end
      end
      for (int e = 0; e < 2; e++) begin
         @(posedge clk_sys) begin
            op_mode <= hsdc_pkg::MODE_NORMAL;
            overvoltage_shutdown_enable <= e[0];
            supply_overvoltage <= 1'b1;
         end
         settle(3);
         check({6'h00, switch_drive}, (e == 1) ? 8'h00 : 8'h03);
         @(posedge clk_sys) supply_overvoltage <= 1'b0;
         settle(3);
         check({6'h00, switch_drive}, (e == 1) ? 8'h00 : 8'h03);
         spi_xfer(hsdc_pkg::ADDR_HIGH_SIDE, 4'h3, 8, r);
         check({6'h00, switch_drive}, 8'h03);
      end
      end_sim();
   end
endmodule // tb_top
